// File: dv/fgp_pins.sv
`timescale 1ns/1ns
module fgp_pins
    import fgp_pkg::*;
(
    input  wire logic [fgp_pkg::NPIN-1:0] out_i,
    input  wire logic [fgp_pkg::NPIN-1:0] oe_i,
    input  wire logic [fgp_pkg::NPIN-1:0] ext_i,
    output logic      [fgp_pkg::NPIN-1:0] lvl_o
);
    // outside circuit drives only where the port has let go
    assign lvl_o = (oe_i & out_i) | (~oe_i & ext_i);
endmodule

// File: dv/fgp_port_chk.sv
`timescale 1ns/1ns
module fgp_port_chk
    import fgp_pkg::*;
(
    input wire logic                       CLOCK_I,
    input wire logic                       RESET_I,
    input wire logic [fgp_pkg::ADDR_W-1:0] ADDR_I,
    input wire logic [31:0]                WDATA_I,
    input wire logic [3:0]                 BE_I,
    input wire logic                       WR_I,
    input wire logic                       RD_I,
    input wire logic [31:0]                RDATA_O,
    input wire logic [fgp_pkg::NPIN-1:0]   GPIO_O,
    input wire logic [fgp_pkg::NPIN-1:0]   GPIO_OE_O,
    input wire logic [fgp_pkg::NPIN-1:0]   PERIPH_SEL_I,
    input wire logic [fgp_pkg::NPIN-1:0]   PERIPH_OUT_I,
    input wire logic [fgp_pkg::NPIN-1:0]   PERIPH_OE_I,
    input wire logic                       EXT_REQ_I,
    input wire logic                       SHARED_EXTERNAL_INTERRUPT_LINE_O
);
    default clocking cb @(posedge CLOCK_I); endclocking
    default disable iff (RESET_I);
    sequence s_wr_dir0; WR_I && ADDR_I == 10'h000 && BE_I == 4'hF; endsequence
    sequence s_wr_set0; WR_I && ADDR_I == 10'h00C; endsequence
    sequence s_wr_clr0; WR_I && ADDR_I == 10'h010; endsequence
    sequence s_rd_dir0; RD_I && ADDR_I == 10'h000 && PERIPH_SEL_I[31:0] == 32'h0; endsequence
    chk_rdata_idle: assert property (RDATA_O != 32'h0 |-> $past(RD_I)) else $error("read data outside slot");
    chk_periph_out: assert property (((GPIO_O ^ PERIPH_OUT_I) & PERIPH_SEL_I) == '0) else $error("claimed pin value");
    chk_periph_oe: assert property (((GPIO_OE_O ^ PERIPH_OE_I) & PERIPH_SEL_I) == '0) else $error("claimed pin enable");
    chk_reset_input: assert property ($fell(RESET_I) |-> (GPIO_OE_O & ~PERIPH_SEL_I) == '0) else $error("pin driven after reset");
    chk_dir_write: assert property (s_wr_dir0 |=> (GPIO_OE_O[31:0] & ~PERIPH_SEL_I[31:0]) ==
        ($past(WDATA_I) & ~PERIPH_SEL_I[31:0])) else $error("direction not applied");
    chk_set_keep: assert property (s_wr_set0 |=> ((GPIO_O[31:0] ^ $past(GPIO_O[31:0])) & ~$past(WDATA_I)) == 32'h0)
        else $error("set touched zero bits");
    chk_clr_low: assert property (s_wr_clr0 |=> (GPIO_O[31:0] & $past(WDATA_I) & ~$past(GPIO_O[31:0])) == 32'h0)
        else $error("clear raised a bit");
    chk_read_dir: assert property (s_rd_dir0 |=> RDATA_O == $past(GPIO_OE_O[31:0])) else $error("direction readback");
    chk_ext_line: assert property (EXT_REQ_I |=> SHARED_EXTERNAL_INTERRUPT_LINE_O) else $error("shared request lost");
    chk_line_hold: assert property (SHARED_EXTERNAL_INTERRUPT_LINE_O && !$past(EXT_REQ_I) && !$past(WR_I)
        |=> SHARED_EXTERNAL_INTERRUPT_LINE_O) else $error("line dropped without clear");
endmodule
bind fgp_port fgp_port_chk u_chk (.CLOCK_I(CLOCK_I), .RESET_I(RESET_I), .ADDR_I(ADDR_I), .WDATA_I(WDATA_I),
    .BE_I(BE_I), .WR_I(WR_I), .RD_I(RD_I), .RDATA_O(RDATA_O), .GPIO_O(GPIO_O), .GPIO_OE_O(GPIO_OE_O),
    .PERIPH_SEL_I(PERIPH_SEL_I), .PERIPH_OUT_I(PERIPH_OUT_I), .PERIPH_OE_I(PERIPH_OE_I), .EXT_REQ_I(EXT_REQ_I),
    .SHARED_EXTERNAL_INTERRUPT_LINE_O(SHARED_EXTERNAL_INTERRUPT_LINE_O));

// File: dv/test_fast_gpio_port_with_edge_irq.sv
`timescale 1ns/1ns
module test_fast_gpio_port_with_edge_irq;
    import fgp_pkg::*;
    logic              clk;
    logic              rst;
    logic [ADDR_W-1:0] addr;
    logic [31:0]       wdata;
    logic [3:0]        be;
    logic              wr;
    logic              rd;
    logic [31:0]       rdata;
    logic [NPIN-1:0]   pin;
    logic [NPIN-1:0]   pout;
    logic [NPIN-1:0]   poe;
    logic [NPIN-1:0]   ext;
    logic [NPIN-1:0]   psel;
    logic [NPIN-1:0]   pdat;
    logic [NPIN-1:0]   pen;
    logic              xreq;
    logic              line;
    logic              wake;
    int                error_cnt;
    int                samples_checked;

    fgp_port DUT (.CLOCK_I(clk), .RESET_I(rst), .ADDR_I(addr), .WDATA_I(wdata), .BE_I(be), .WR_I(wr), .RD_I(rd),
        .RDATA_O(rdata), .GPIO_I(pin), .GPIO_O(pout), .GPIO_OE_O(poe), .PERIPH_SEL_I(psel), .PERIPH_OUT_I(pdat),
        .PERIPH_OE_I(pen), .EXT_REQ_I(xreq), .SHARED_EXTERNAL_INTERRUPT_LINE_O(line), .WAKE_O(wake));
    fgp_pins u_pins (.out_i(pout), .oe_i(poe), .ext_i(ext), .lvl_o(pin));

    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    task automatic cmp(input string n, input logic [31:0] e, input logic [31:0] g);
        samples_checked++;
        if (g !== e) begin
            error_cnt++;
            $display("MISMATCH %s expected %h seen %h", n, e, g);
        end
    endtask

    task automatic wr_reg(input logic [9:0] a, input logic [31:0] d, input logic [3:0] b);
        @(posedge clk);
        wr <= 1'b1;
        addr <= a;
        wdata <= d;
        be <= b;
        @(posedge clk);
        wr <= 1'b0;
    endtask

    // read data stand only in the cycle after the read edge
    task automatic rd_chk(input string n, input logic [9:0] a, input logic [31:0] e);
        @(posedge clk);
        rd <= 1'b1;
        addr <= a;
        @(posedge clk);
        rd <= 1'b0;
        #1;
        cmp(n, e, rdata);
    endtask

    task automatic wait_cyc(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask

    task automatic t_reset();
        for (int p = 0; p < NPORT; p++) rd_chk("dir", 10'(p * 32), 32'h0);
    endtask

    task automatic t_dir();
        wr_reg(10'h020, 32'hFFFFFFFF, 4'h2);
        rd_chk("dir byte", 10'h020, 32'h0000FF00);
        wr_reg(10'h020, 32'h00AA0000, 4'hC);
        rd_chk("dir half", 10'h020, 32'h00AAFF00);
        cmp("oe", 32'h00AAFF00, poe[63:32]);
        @(posedge clk);
        ext[63:32] <= 32'h3C3C0F0F;
        wait_cyc(4);
        rd_chk("pin level", 10'h028, 32'h3C14000F);
    endtask

    task automatic t_setclr();
        wr_reg(10'h000, 32'hFFFFFF00, 4'hF);
        wr_reg(10'h008, 32'h12345600, 4'hF);
        rd_chk("out", 10'h014, 32'h12345600);
        wr_reg(10'h00C, 32'h0000F000, 4'hF);
        wr_reg(10'h010, 32'h00300000, 4'hF);
        rd_chk("out", 10'h014, 32'h1204F600);
        cmp("gpio", 32'h1204F600, pout[31:0]);
        rd_chk("dir", 10'h000, 32'hFFFFFF00);
        rd_chk("pins", 10'h008, 32'h1204F600);
        @(posedge clk);
        psel[96] <= 1'b1;
        pdat[96] <= 1'b1;
        pen[96] <= 1'b1;
        wait_cyc(1);
        cmp("claimed", 32'h3, {30'h0, pout[96], poe[96]});
    endtask

    task automatic t_mask();
        wr_reg(10'h080, 32'hFFFFFFFF, 4'hF);
        wr_reg(10'h084, 32'h0000FFFF, 4'hF);
        wr_reg(10'h088, 32'hA5A5A5A5, 4'hF);
        rd_chk("masked", 10'h094, 32'hA5A50000);
        wr_reg(10'h08C, 32'hFFFFFFFF, 4'hF);
        wr_reg(10'h084, 32'h00000000, 4'hF);
        rd_chk("unmasked", 10'h094, 32'hFFFF0000);
        cmp("gpio", 32'hFFFF0000, pout[159:128]);
    endtask

    task automatic t_edge();
        @(posedge clk);
        ext[78:77] <= 2'h3;
        wr_reg(10'h100, 32'h00000001, 4'hF);
        wr_reg(10'h114, 32'hFFFFFFFF, 4'hF);
        rd_chk("fall en", 10'h114, 32'h00003FFF);
        @(posedge clk);
        ext[0] <= 1'b1;
        #1;
        cmp("wake", 32'h1, {31'h0, wake});
        wait_cyc(8);
        cmp("wake off", 32'h0, {31'h0, wake});
        cmp("line", 32'h1, {31'h0, line});
        rd_chk("rise sta", 10'h108, 32'h00000001);
        @(posedge clk);
        ext[78:77] <= 2'h0;
        ext[0] <= 1'b0;
        wait_cyc(8);
        rd_chk("fall sta", 10'h11C, 32'h00002000);
        rd_chk("fall off", 10'h10C, 32'h00000000);
        rd_chk("summary", 10'h120, 32'h00000003);
        wr_reg(10'h108, 32'h00000001, 4'hF);
        wr_reg(10'h11C, 32'hFFFFFFFF, 4'hF);
        wait_cyc(3);
        cmp("line", 32'h0, {31'h0, line});
        @(posedge clk);
        xreq <= 1'b1;
        wait_cyc(2);
        cmp("line", 32'h1, {31'h0, line});
        @(posedge clk);
        xreq <= 1'b0;
    endtask

    task automatic t_legacy();
        wr_reg(10'h218, 32'h12345678, 4'hF);
        rd_chk("legacy dir", 10'h020, 32'h12345678);
        wr_reg(10'h204, 32'h000000FF, 4'h1);
        rd_chk("legacy set", 10'h204, 32'h1204F6FF);
        rd_chk("legacy pin", 10'h200, 32'h1204F600);
        wr_reg(10'h20C, 32'h00000F00, 4'hF);
        rd_chk("legacy clr", 10'h014, 32'h1204F0FF);
        rd_chk("unmapped", 10'h3FC, 32'h00000000);
    endtask

    task automatic end_sim();
        $display("checks %0d mismatches %0d", samples_checked, error_cnt);
        if (error_cnt == 0 && samples_checked > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    initial begin
        {addr, wdata, be, wr, rd, ext, psel, pdat, pen, xreq} = '0;
        error_cnt = 0;
        samples_checked = 0;
        rst = 1'b1;
        repeat (8) @(posedge clk);
        rst <= 1'b0;
        t_reset();
        t_dir();
        t_setclr();
        t_mask();
        t_edge();
        t_legacy();
        end_sim();
    end

    // the whole sequence needs about 125 cycles
    initial begin
        #20000;
        error_cnt++;
        end_sim();
    end
endmodule

// File: hw/fgp_edge_cell.sv
`timescale 1ns/1ns
module fgp_edge_cell (
    input  wire logic clk_i,
    input  wire logic rst_i,
    input  wire logic pin_i,
    input  wire logic rise_en_i,
    input  wire logic fall_en_i,
    output logic      rise_ev_o,
    output logic      fall_ev_o,
    output logic      wake_o
);
    logic rise_tgl;
    logic fall_tgl;
    logic r_s1, r_s2, r_s3;
    logic f_s1, f_s2, f_s3;

    // the pin itself clocks the capture, so edges land with the system clock stopped
    always_ff @(posedge pin_i or posedge rst_i) begin
        if (rst_i) begin
            rise_tgl <= 1'b0;
        end else if (rise_en_i) begin
            rise_tgl <= ~rise_tgl;
        end
    end

    always_ff @(negedge pin_i or posedge rst_i) begin
        if (rst_i) begin
            fall_tgl <= 1'b0;
        end else if (fall_en_i) begin
            fall_tgl <= ~fall_tgl;
        end
    end

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            r_s1 <= 1'b0;
            r_s2 <= 1'b0;
            r_s3 <= 1'b0;
            f_s1 <= 1'b0;
            f_s2 <= 1'b0;
            f_s3 <= 1'b0;
        end else begin
            r_s1 <= rise_tgl;
            r_s2 <= r_s1;
            r_s3 <= r_s2;
            f_s1 <= fall_tgl;
            f_s2 <= f_s1;
            f_s3 <= f_s2;
        end
    end

    assign rise_ev_o = r_s2 ^ r_s3;
    assign fall_ev_o = f_s2 ^ f_s3;
    // pending edge not yet seen by the clocked side; holds while clocks are stopped
    assign wake_o = (rise_tgl ^ r_s3) | (fall_tgl ^ f_s3);

endmodule

// File: hw/fgp_pkg.sv
package fgp_pkg;

    // geometry
    localparam int NPORT  = 5;
    localparam int PW     = 32;
    localparam int ADDR_W = 10;
    localparam int NIRQ   = 2;
    localparam int NLEG   = 2;
    localparam int NPIN   = NPORT * PW;

    // which fast ports carry edge cells, and which of their pins are digital capable (46 in all)
    localparam int          IRQ_PORT [NIRQ] = '{0, 2};
    localparam logic [31:0] IRQ_CAP  [NIRQ] = '{32'hFFFFFFFF, 32'h00003FFF};

    // address regions, ADDR_I[9:8]
    localparam logic [1:0] RGN_FAST = 2'h0;
    localparam logic [1:0] RGN_IRQ  = 2'h1;
    localparam logic [1:0] RGN_LEG  = 2'h2;

    // fast port block: port at ADDR_I[7:5], register at ADDR_I[4:2]
    localparam logic [2:0] FR_DIR  = 3'h0;
    localparam logic [2:0] FR_MASK = 3'h1;
    localparam logic [2:0] FR_PIN  = 3'h2;
    localparam logic [2:0] FR_SET  = 3'h3;
    localparam logic [2:0] FR_CLR  = 3'h4;
    localparam logic [2:0] FR_OUT  = 3'h5;

    // edge block: group at ADDR_I[5:4], register at ADDR_I[3:2]
    localparam logic [1:0] IR_REN  = 2'h0;
    localparam logic [1:0] IR_FEN  = 2'h1;
    localparam logic [1:0] IR_RSTA = 2'h2;
    localparam logic [1:0] IR_FSTA = 2'h3;
    localparam logic [1:0] IG_SUM  = 2'h2;

    // legacy block: port at ADDR_I[4], register at ADDR_I[3:2]
    localparam logic [1:0] LR_PIN = 2'h0;
    localparam logic [1:0] LR_SET = 2'h1;
    localparam logic [1:0] LR_DIR = 2'h2;
    localparam logic [1:0] LR_CLR = 2'h3;

    // reset values
    localparam logic [31:0] DIR_RST  = 32'h00000000;
    localparam logic [31:0] MASK_RST = 32'h00000000;
    localparam logic [31:0] OUT_RST  = 32'h00000000;
    localparam logic [31:0] EN_RST   = 32'h00000000;
    localparam logic [31:0] RD_NONE  = 32'h00000000;

endpackage

// File: hw/fgp_port.sv
// Strobed register access and the placing of the registers were decided locally.
`timescale 1ns/1ns
module fgp_port (
    input  wire logic                              CLOCK_I,
    input  wire logic                              RESET_I,
    input  wire logic [fgp_pkg::ADDR_W-1:0]        ADDR_I,
    input  wire logic [31:0]                       WDATA_I,
    input  wire logic [3:0]                        BE_I,
    input  wire logic                              WR_I,
    input  wire logic                              RD_I,
    output logic      [31:0]                       RDATA_O,
    input  wire logic [fgp_pkg::NPIN-1:0]          GPIO_I,
    output logic      [fgp_pkg::NPIN-1:0]          GPIO_O,
    output logic      [fgp_pkg::NPIN-1:0]          GPIO_OE_O,
    input  wire logic [fgp_pkg::NPIN-1:0]          PERIPH_SEL_I,
    input  wire logic [fgp_pkg::NPIN-1:0]          PERIPH_OUT_I,
    input  wire logic [fgp_pkg::NPIN-1:0]          PERIPH_OE_I,
    input  wire logic                              EXT_REQ_I,
    output logic                                   SHARED_EXTERNAL_INTERRUPT_LINE_O,
    output logic                                   WAKE_O
);
    import fgp_pkg::*;

    function automatic logic [31:0] lane_mask(input logic [3:0] be);
        logic [31:0] m;
        m = 32'h00000000;
        for (int i = 0; i < 4; i++) begin
            m[i*8 +: 8] = {8{be[i]}};
        end
        return m;
    endfunction

    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nv, input logic [31:0] m);
        return (old & ~m) | (nv & m);
    endfunction

    // one group has any rising or falling status standing
    function automatic logic grp_any(input logic [31:0] rs, input logic [31:0] fs);
        return |(rs | fs);
    endfunction

    // bus decode
    wire        [1:0]  rgn     = ADDR_I[9:8];
    wire        [2:0]  f_port  = ADDR_I[7:5];
    wire        [2:0]  f_reg   = ADDR_I[4:2];
    wire        [1:0]  i_grp   = ADDR_I[5:4];
    wire        [1:0]  i_reg   = ADDR_I[3:2];
    wire               l_port  = ADDR_I[4];
    wire        [1:0]  l_reg   = ADDR_I[3:2];
    wire               hi_zero = (ADDR_I[7:6] == 2'h0);
    wire               fast_ok = (rgn == RGN_FAST) && (f_port < 3'(NPORT));
    wire               irq_ok  = (rgn == RGN_IRQ) && hi_zero;
    wire               leg_ok  = (rgn == RGN_LEG) && hi_zero && (ADDR_I[5] == 1'b0);
    wire        [31:0] lanes   = lane_mask(BE_I);

    // storage
    logic [31:0] dir_r  [NPORT];
    logic [31:0] mask_r [NPORT];
    logic [31:0] out_r  [NPORT];
    logic [31:0] ren_r  [NIRQ];
    logic [31:0] fen_r  [NIRQ];
    logic [31:0] rsta_r [NIRQ];
    logic [31:0] fsta_r [NIRQ];
    logic [31:0] next_dir  [NPORT];
    logic [31:0] next_mask [NPORT];
    logic [31:0] next_out  [NPORT];
    logic [31:0] next_ren  [NIRQ];
    logic [31:0] next_fen  [NIRQ];
    logic [31:0] next_rsta [NIRQ];
    logic [31:0] next_fsta [NIRQ];
    logic [31:0] rise_ev   [NIRQ];
    logic [31:0] fall_ev   [NIRQ];
    logic [31:0] wake_v    [NIRQ];
    logic [NPIN-1:0] pin_s1;
    logic [NPIN-1:0] pin_s2;
    logic [31:0]     next_rdata;
    logic            irq_any;

    // pins are asynchronous: two flops before the read path sees them
    always_ff @(posedge CLOCK_I or posedge RESET_I) begin
        if (RESET_I) begin
            pin_s1 <= '0;
            pin_s2 <= '0;
        end else begin
            pin_s1 <= GPIO_I;
            pin_s2 <= pin_s1;
        end
    end

    // register writes
    always_comb begin
        logic [31:0] wm;
        logic        hit;
        wm = 32'h00000000;
        hit = 1'b0;
        for (int p = 0; p < NPORT; p++) begin
            next_dir[p]  = dir_r[p];
            next_mask[p] = mask_r[p];
            next_out[p]  = out_r[p];
            hit = WR_I && fast_ok && (f_port == 3'(p));
            wm = lanes & ~mask_r[p];
            if (hit) begin
                case (f_reg)
                    FR_DIR: begin
                        next_dir[p] = merge(dir_r[p], WDATA_I, lanes);
                    end
                    FR_MASK: begin
                        next_mask[p] = merge(mask_r[p], WDATA_I, lanes);
                    end
                    FR_PIN: begin
                        next_out[p] = merge(out_r[p], WDATA_I, wm);
                    end
                    FR_SET: begin
                        next_out[p] = out_r[p] | (WDATA_I & wm);
                    end
                    FR_CLR: begin
                        next_out[p] = out_r[p] & ~(WDATA_I & wm);
                    end
                    default: begin
                    end
                endcase
            end
            // legacy copy, full word, no mask
            if (p < NLEG && WR_I && leg_ok && (l_port == 1'(p))) begin
                case (l_reg)
                    LR_PIN: begin
                        next_out[p] = WDATA_I;
                    end
                    LR_SET: begin
                        next_out[p] = out_r[p] | WDATA_I;
                    end
                    LR_DIR: begin
                        next_dir[p] = WDATA_I;
                    end
                    LR_CLR: begin
                        next_out[p] = out_r[p] & ~WDATA_I;
                    end
                    default: begin
                    end
                endcase
            end
        end
    end

    // edge enables and sticky status
    always_comb begin
        logic        hit;
        logic [31:0] clr_r;
        logic [31:0] clr_f;
        hit = 1'b0;
        clr_r = 32'h00000000;
        clr_f = 32'h00000000;
        for (int j = 0; j < NIRQ; j++) begin
            hit = WR_I && irq_ok && (i_grp == 2'(j));
            clr_r = (hit && i_reg == IR_RSTA) ? (WDATA_I & lanes) : 32'h00000000;
            clr_f = (hit && i_reg == IR_FSTA) ? (WDATA_I & lanes) : 32'h00000000;
            // only digital-capable pins can be enabled
            next_ren[j] = (hit && i_reg == IR_REN) ? merge(ren_r[j], WDATA_I & IRQ_CAP[j], lanes) : ren_r[j];
            next_fen[j] = (hit && i_reg == IR_FEN) ? merge(fen_r[j], WDATA_I & IRQ_CAP[j], lanes) : fen_r[j];
            // a new edge wins over a clear in the same cycle
            next_rsta[j] = (rsta_r[j] & ~clr_r) | rise_ev[j];
            next_fsta[j] = (fsta_r[j] & ~clr_f) | fall_ev[j];
        end
    end

    always_ff @(posedge CLOCK_I or posedge RESET_I) begin
        if (RESET_I) begin
            for (int p = 0; p < NPORT; p++) begin
                dir_r[p]  <= DIR_RST;
                mask_r[p] <= MASK_RST;
                out_r[p]  <= OUT_RST;
            end
            for (int j = 0; j < NIRQ; j++) begin
                ren_r[j]  <= EN_RST;
                fen_r[j]  <= EN_RST;
                rsta_r[j] <= EN_RST;
                fsta_r[j] <= EN_RST;
            end
        end else begin
            dir_r  <= next_dir;
            mask_r <= next_mask;
            out_r  <= next_out;
            ren_r  <= next_ren;
            fen_r  <= next_fen;
            rsta_r <= next_rsta;
            fsta_r <= next_fsta;
        end
    end

    // edge cells on the raw pins
    for (genvar j = 0; j < NIRQ; j++) begin : g_grp
        for (genvar b = 0; b < PW; b++) begin : g_bit
            fgp_edge_cell u_cell (
                .clk_i     (CLOCK_I),
                .rst_i     (RESET_I),
                .pin_i     (GPIO_I[IRQ_PORT[j]*PW + b]),
                .rise_en_i (ren_r[j][b]),
                .fall_en_i (fen_r[j][b]),
                .rise_ev_o (rise_ev[j][b]),
                .fall_ev_o (fall_ev[j][b]),
                .wake_o    (wake_v[j][b])
            );
        end
    end

    // read path
    always_comb begin
        logic [31:0] pins;
        pins = 32'h00000000;
        next_rdata = RD_NONE;
        if (fast_ok) begin
            for (int p = 0; p < NPORT; p++) begin
                if (f_port == 3'(p)) begin
                    pins = pin_s2[p*PW +: PW];
                    case (f_reg)
                        FR_DIR: begin
                            next_rdata = dir_r[p];
                        end
                        FR_MASK: begin
                            next_rdata = mask_r[p];
                        end
                        FR_PIN: begin
                            next_rdata = pins & ~mask_r[p];
                        end
                        FR_SET: begin
                            next_rdata = out_r[p] & ~mask_r[p];
                        end
                        // clear is write-only, so a read returns nothing
                        FR_CLR: begin
                            next_rdata = RD_NONE;
                        end
                        FR_OUT: begin
                            next_rdata = out_r[p] & ~mask_r[p];
                        end
                        default: begin
                            next_rdata = RD_NONE;
                        end
                    endcase
                end
            end
        end else if (irq_ok) begin
            for (int j = 0; j < NIRQ; j++) begin
                if (i_grp == 2'(j)) begin
                    case (i_reg)
                        IR_REN: begin
                            next_rdata = ren_r[j];
                        end
                        IR_FEN: begin
                            next_rdata = fen_r[j];
                        end
                        IR_RSTA: begin
                            next_rdata = rsta_r[j];
                        end
                        IR_FSTA: begin
                            next_rdata = fsta_r[j];
                        end
                        default: begin
                            next_rdata = RD_NONE;
                        end
                    endcase
                end
            end
            // summary lets one read find the group that needs service
            if (i_grp == IG_SUM && i_reg == 2'h0) begin
                next_rdata = {30'h00000000, grp_any(rsta_r[1], fsta_r[1]), grp_any(rsta_r[0], fsta_r[0])};
            end
        end else if (leg_ok) begin
            for (int p = 0; p < NLEG; p++) begin
                if (l_port == 1'(p)) begin
                    case (l_reg)
                        LR_PIN: begin
                            next_rdata = pin_s2[p*PW +: PW];
                        end
                        // legacy view has no mask, so the whole register shows
                        LR_SET: begin
                            next_rdata = out_r[p];
                        end
                        LR_DIR: begin
                            next_rdata = dir_r[p];
                        end
                        LR_CLR: begin
                            next_rdata = RD_NONE;
                        end
                        default: begin
                            next_rdata = RD_NONE;
                        end
                    endcase
                end
            end
        end
    end

    // line held while any status bit stands
    assign irq_any = grp_any(rsta_r[0], fsta_r[0]) | grp_any(rsta_r[1], fsta_r[1]);

    // read data valid only the cycle after the strobe
    always_ff @(posedge CLOCK_I or posedge RESET_I) begin
        if (RESET_I) begin
            RDATA_O <= RD_NONE;
            SHARED_EXTERNAL_INTERRUPT_LINE_O <= 1'b0;
        end else begin
            RDATA_O <= RD_I ? next_rdata : RD_NONE;
            // merged with the other requests of the line
            SHARED_EXTERNAL_INTERRUPT_LINE_O <= irq_any | EXT_REQ_I;
        end
    end

    // pin drive
    for (genvar p = 0; p < NPORT; p++) begin : g_drv
        wire [31:0] sel = PERIPH_SEL_I[p*PW +: PW];
        // port logic owns every unclaimed pin
        assign GPIO_O[p*PW +: PW]    = (sel & PERIPH_OUT_I[p*PW +: PW]) | (~sel & out_r[p]);
        assign GPIO_OE_O[p*PW +: PW] = (sel & PERIPH_OE_I[p*PW +: PW]) | (~sel & dir_r[p]);
    end

    // no clock needed, stays up until the clocked side has seen the edge
    assign WAKE_O = |(wake_v[0] | wake_v[1]);

endmodule
